/* rtl/dci_ca_port.sv */
// ddr3 x8 command, address and control pin interface with apb register access
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - capture control and address at clock rise
// - clock enable high runs clocks, buffers, drivers
// - clock enable low picks power-down or self-refresh
// - self-refresh exit sees asynchronous clock enable
// - power-down keeps only clock, odt, cke buffers
// - self-refresh keeps only the clock enable buffer
// - chip select high masks the command
// - command decoded from strobes and chip select
// - masked write beats are discarded
// - data mask sampled on both strobe edges
// - mr1 bit 11 picks mask or termination strobe
// - bank address selects the targeted bank
// - bank address picks mode register on mrs
// - a10 high on access means auto-precharge
// - a10 high on precharge closes all banks
// - row from a0-a14, column from address
// - mrs loads address as opcode
// - a12 low chops burst when on-the-fly
// - odt terminates data, strobes, mask, tdqs_n
// - odt ignored when all termination disabled
// - bit 11 clear means pure data mask
module dci_ca_port
  import dci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command and address pins, sampled on the clock rise
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // write data pins
  input wire logic dqs,
  input wire logic [DQ_W-1:0] dq,
  input wire logic dm_tdqs,
  // decoded command
  output logic cmd_valid,
  output dci_cmd_type cmd_code,
  output logic [BA_W-1:0] cmd_bank,
  output logic [ADDR_W-1:0] cmd_row,
  output logic [COL_W-1:0] cmd_col,
  output logic cmd_auto_pre,
  output logic cmd_pre_all,
  output logic cmd_chop,
  // write beats after masking
  output logic beat_valid,
  output logic [DQ_W-1:0] beat_data,
  output logic beat_keep,
  // power and termination controls
  output logic int_clk_en,
  output logic out_drv_en,
  output logic ca_buf_en,
  output logic ck_buf_en,
  output logic odt_buf_en,
  output logic term_en,
  output logic term_tdqs_n_en,
  output logic mask_mode
);

  // whole module state
  typedef struct packed {
    dci_ps_type ps; // power state
    logic cke_s1; // clock enable synchroniser, first stage
    logic cke_s2; // second stage
    logic cke_s3; // history for rise detection
    logic odt_q; // registered termination request
    logic [3:0][ADDR_W-1:0] mr; // mode registers 0..3
    logic dec_en; // software decode enable
    logic [NBANK-1:0] open_banks; // banks with an open row
    logic [15:0] cmd_cnt; // accepted commands
    logic cmd_valid;
    dci_cmd_type cmd;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic pre_all;
    logic chop;
    logic dqs_q; // previous strobe level
    logic wr_active; // write burst window
    logic [3:0] beats_left; // beats still expected
    logic beat_valid;
    logic [DQ_W-1:0] beat_data;
    logic beat_keep;
    logic [31:0] prdata;
  } dci_state_type;

  dci_state_type st_reg; // registered state
  dci_state_type st_next; // next state
  dci_cmd_type cmd_in; // command on the pins this cycle
  logic rtt_on; // some termination enabled
  logic tdqs_mode; // pin is termination strobe
  logic chop_in; // chop decision for this access
  logic apb_wr; // apb write access phase
  logic [31:0] rd_word; // read mux

  // termination and pin mode from the mode registers
  always_comb
  begin
    rtt_on = st_reg.mr[1][MR1_RTT2_BIT] | st_reg.mr[1][MR1_RTT1_BIT] |
             st_reg.mr[1][MR1_RTT0_BIT] | (|st_reg.mr[2][MR2_RTTWR_LSB +: 2]);
    tdqs_mode = st_reg.mr[1][MR1_TDQS_BIT];
    cmd_in = dci_decode(cs_n, ras_n, cas_n, we_n);
    // fixed mode decides unless on-the-fly, then a12 low chops
    if (st_reg.mr[0][MR0_BL_LSB +: 2] == BL_OTF)
    begin
      chop_in = !addr[BC_BIT];
    end
    else
    begin
      chop_in = (st_reg.mr[0][MR0_BL_LSB +: 2] == BL_BC4);
    end
    apb_wr = psel && penable && pwrite;
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_word[CTRL_DEC_EN_BIT] = st_reg.dec_en;
      OFS_STATUS:
      begin
        rd_word[STAT_PS_LSB +: 4] = st_reg.ps;
        rd_word[STAT_OPEN_LSB +: NBANK] = st_reg.open_banks;
        rd_word[STAT_WR_BIT] = st_reg.wr_active;
      end
      OFS_MR0: rd_word[ADDR_W-1:0] = st_reg.mr[0];
      OFS_MR1: rd_word[ADDR_W-1:0] = st_reg.mr[1];
      OFS_MR2: rd_word[ADDR_W-1:0] = st_reg.mr[2];
      OFS_MR3: rd_word[ADDR_W-1:0] = st_reg.mr[3];
      OFS_CMDCNT: rd_word[15:0] = st_reg.cmd_cnt;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next-state logic: the pins are taken at each rising edge of pclk
  always_comb
  begin
    st_next = st_reg;
    st_next.cmd_valid = 1'b0;
    st_next.beat_valid = 1'b0;
    // first stage feeds only the second; rise seen between second and third
    st_next.cke_s1 = cke;
    st_next.cke_s2 = st_reg.cke_s1;
    st_next.cke_s3 = st_reg.cke_s2;
    st_next.dqs_q = dqs;
    // odt receiver is dead in self-refresh
    st_next.odt_q = (st_reg.ps == PS_SELF_REF) ? 1'b0 : odt;

    // apb read data registered in the setup cycle
    if (psel && !penable)
    begin
      st_next.prdata = rd_word;
    end
    // apb writes; an mrs in the same cycle overrides below
    if (apb_wr)
    begin
      case (paddr)
        OFS_CTRL: st_next.dec_en = pwdata[CTRL_DEC_EN_BIT];
        OFS_MR0: st_next.mr[0] = pwdata[ADDR_W-1:0];
        OFS_MR1: st_next.mr[1] = pwdata[ADDR_W-1:0];
        OFS_MR2: st_next.mr[2] = pwdata[ADDR_W-1:0];
        OFS_MR3: st_next.mr[3] = pwdata[ADDR_W-1:0];
        default: st_next.dec_en = st_reg.dec_en; // read-only or unmapped
      endcase
    end

    // write beats on either strobe edge; clock enable stays high here
    if (st_reg.wr_active && (dqs != st_reg.dqs_q))
    begin
      st_next.beat_valid = 1'b1;
      st_next.beat_data = dq;
      st_next.beat_keep = !(dm_tdqs && !tdqs_mode);
      st_next.beats_left = st_reg.beats_left - 4'h1;
      if (st_reg.beats_left == 4'h1)
      begin
        st_next.wr_active = 1'b0;
      end
    end

    case (st_reg.ps)
      PS_ACTIVE:
      begin
        if (!cke)
        begin
          // clock enable low stops the core; a refresh with all banks closed picks self-refresh, else bank state picks the power-down
          if (cmd_in == CMD_REF && st_reg.open_banks == '0)
          begin
            st_next.ps = PS_SELF_REF;
          end
          else if (st_reg.open_banks != '0)
          begin
            st_next.ps = PS_PD_ACT;
          end
          else
          begin
            st_next.ps = PS_PD_PRE;
          end
        end
        else if (st_reg.dec_en && cmd_in != CMD_DES && cmd_in != CMD_NOP)
        begin
          st_next.cmd_valid = 1'b1;
          st_next.cmd = cmd_in;
          st_next.bank = ba;
          st_next.cmd_cnt = st_reg.cmd_cnt + 16'h0001;
          st_next.auto_pre = 1'b0;
          st_next.pre_all = 1'b0;
          st_next.chop = 1'b0;
          case (cmd_in)
            CMD_ACT:
            begin
              st_next.row = addr;
              st_next.open_banks[ba] = 1'b1;
            end
            CMD_RD, CMD_WR:
            begin
              st_next.col = addr[COL_W-1:0];
              st_next.auto_pre = addr[AP_BIT];
              st_next.chop = chop_in;
              if (addr[AP_BIT])
              begin
                st_next.open_banks[ba] = 1'b0;
              end
              if (cmd_in == CMD_WR)
              begin
                st_next.wr_active = 1'b1;
                st_next.beats_left = chop_in ? BEATS_BC4 : BEATS_BL8;
              end
            end
            CMD_PRE:
            begin
              st_next.pre_all = addr[AP_BIT];
              if (addr[AP_BIT])
              begin
                st_next.open_banks = '0;
              end
              else
              begin
                st_next.open_banks[ba] = 1'b0;
              end
            end
            CMD_MRS:
            begin
              // low two bank bits choose the register, bank bit 2 unused
              st_next.mr[ba[1:0]] = addr;
            end
            default:
            begin
              // refresh and calibration only pass through
              st_next.row = st_reg.row;
            end
          endcase
        end
      end
      PS_PD_PRE, PS_PD_ACT:
      begin
        // clock enable receiver stays live in power-down
        if (cke)
        begin
          st_next.ps = PS_ACTIVE;
        end
      end
      PS_SELF_REF:
      begin
        // exit only on a synchronised rise, so the stale high at entry is ignored
        if (st_reg.cke_s2 && !st_reg.cke_s3)
        begin
          st_next.ps = PS_ACTIVE;
        end
      end
      default: st_next.ps = PS_ACTIVE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.ps <= PS_ACTIVE;
      st_reg.dec_en <= CTRL_DEC_EN_RST;
      st_reg.mr <= {4{MR_RST}};
      st_reg.cmd <= CMD_DES;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // apb answers with no wait state
  assign pready = 1'b1;
  assign pslverr = psel && penable && !dci_mapped(paddr);
  assign prdata = st_reg.prdata;

  // decoded command and write beat outputs
  assign cmd_valid = st_reg.cmd_valid;
  assign cmd_code = st_reg.cmd;
  assign cmd_bank = st_reg.bank;
  assign cmd_row = st_reg.row;
  assign cmd_col = st_reg.col;
  assign cmd_auto_pre = st_reg.auto_pre;
  assign cmd_pre_all = st_reg.pre_all;
  assign cmd_chop = st_reg.chop;
  assign beat_valid = st_reg.beat_valid;
  assign beat_data = st_reg.beat_data;
  assign beat_keep = st_reg.beat_keep;

  // power gating from the power state
  assign int_clk_en = (st_reg.ps == PS_ACTIVE);
  assign out_drv_en = (st_reg.ps == PS_ACTIVE);
  assign ca_buf_en = (st_reg.ps == PS_ACTIVE);
  assign ck_buf_en = (st_reg.ps != PS_SELF_REF);
  assign odt_buf_en = (st_reg.ps != PS_SELF_REF);
  // termination only while enabled in a mode register
  assign term_en = st_reg.odt_q && rtt_on;
  assign term_tdqs_n_en = term_en && tdqs_mode;
  assign mask_mode = !tdqs_mode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a live command in the active state
  sequence s_live_cmd;
    st_reg.ps == PS_ACTIVE && cke && st_reg.dec_en;
  endsequence
  // a rise of clock enable while in self-refresh
  sequence s_sr_rise;
    (st_reg.ps == PS_SELF_REF && !cke) ##1 cke [*3];
  endsequence

  a_cs_mask: assert property (s_live_cmd and cs_n |=> !cmd_valid)
    else $error("command accepted with chip select high");
  a_cmd_decode: assert property (s_live_cmd and !cs_n and (ras_n ^ cas_n) |=>
    cmd_valid && cmd_code == dci_decode(1'b0, $past(ras_n), $past(cas_n), $past(we_n)))
    else $error("decoded command differs from pins");
  a_bank_capture: assert property (cmd_valid |-> cmd_bank == $past(ba))
    else $error("bank not taken from the sampled pins");
  a_row_capture: assert property (cmd_valid && cmd_code == CMD_ACT |-> cmd_row == $past(addr))
    else $error("row not taken from the address pins");
  a_pd_entry: assert property (st_reg.ps == PS_ACTIVE && !cke && st_reg.open_banks != '0
    |=> st_reg.ps == PS_PD_ACT)
    else $error("active power-down not entered");
  a_sr_exit: assert property (s_sr_rise |=> st_reg.ps == PS_ACTIVE)
    else $error("self-refresh exit missed");
  a_clk_stop: assert property (st_reg.ps == PS_ACTIVE && !cke |=> !int_clk_en && !out_drv_en)
    else $error("clocks still running after clock enable low");
  a_pd_buffers: assert property (st_reg.ps inside {PS_PD_PRE, PS_PD_ACT}
    |-> ck_buf_en && odt_buf_en && !ca_buf_en)
    else $error("wrong buffers in power-down");
  a_sr_buffers: assert property (st_reg.ps == PS_SELF_REF ##1 st_reg.ps == PS_SELF_REF
    |-> !ck_buf_en && !term_en)
    else $error("clock or termination live in self-refresh");
  a_mask_beat: assert property (beat_valid && mask_mode |-> beat_keep == !$past(dm_tdqs))
    else $error("masked beat not discarded");
  a_fall_beat: assert property (st_reg.wr_active && $fell(dqs) |=> beat_valid)
    else $error("falling strobe edge not sampled");
  a_mrs_load: assert property (s_live_cmd and cmd_in == CMD_MRS |=>
    st_reg.mr[$past(ba[1:0])] == $past(addr))
    else $error("mode register not loaded");
  a_auto_pre: assert property (s_live_cmd and cmd_in == CMD_RD and addr[AP_BIT] |=>
    cmd_auto_pre ##0 !st_reg.open_banks[cmd_bank])
    else $error("auto-precharge not applied");
  a_pre_all: assert property (s_live_cmd and cmd_in == CMD_PRE and addr[AP_BIT] |=>
    cmd_pre_all && st_reg.open_banks == '0)
    else $error("precharge all left a bank open");
  a_chop_otf: assert property (cmd_valid && cmd_code inside {CMD_RD, CMD_WR} &&
    st_reg.mr[0][MR0_BL_LSB +: 2] == BL_OTF && $stable(st_reg.mr[0])
    |-> cmd_chop == !$past(addr[BC_BIT]))
    else $error("burst chop not taken from a12");
  a_odt_gate: assert property (!rtt_on || !$past(odt) |-> !term_en && !term_tdqs_n_en)
    else $error("termination applied while disabled");
  a_tdqs_term: assert property (term_tdqs_n_en |-> term_en && tdqs_mode)
    else $error("tdqs_n terminated outside tdqs mode");

endmodule : dci_ca_port
`default_nettype wire

/* rtl/dci_pkg.sv */
// constants, types and decode helpers for the ddr3 command/address pin interface
package dci_pkg;

  // pin widths of the x8 part
  localparam int unsigned ADDR_W = 15; // row address and mode register opcode
  localparam int unsigned BA_W = 3; // bank address
  localparam int unsigned COL_W = 10; // column address
  localparam int unsigned DQ_W = 8; // data byte
  localparam int unsigned NBANK = 8; // banks selected by the bank address

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // control
  localparam logic [7:0] OFS_STATUS = 8'h04; // power state and open banks
  localparam logic [7:0] OFS_MR0 = 8'h08; // mode register 0
  localparam logic [7:0] OFS_MR1 = 8'h0c; // mode register 1
  localparam logic [7:0] OFS_MR2 = 8'h10; // mode register 2
  localparam logic [7:0] OFS_MR3 = 8'h14; // mode register 3
  localparam logic [7:0] OFS_CMDCNT = 8'h18; // accepted command count

  // control and status field positions
  localparam int unsigned CTRL_DEC_EN_BIT = 0; // command decode enable
  localparam logic CTRL_DEC_EN_RST = 1'b1; // decode on after reset
  localparam int unsigned STAT_PS_LSB = 0; // power state, one-hot, 4 bits
  localparam int unsigned STAT_OPEN_LSB = 8; // open bank mask, 8 bits
  localparam int unsigned STAT_WR_BIT = 16; // write burst in progress
  localparam logic [ADDR_W-1:0] MR_RST = 15'h0000; // mode register reset value

  // mode register fields
  localparam int unsigned MR0_BL_LSB = 0; // burst length field, 2 bits
  localparam logic [1:0] BL_OTF = 2'h1; // chop selected on the fly
  localparam logic [1:0] BL_BC4 = 2'h2; // fixed chopped burst
  localparam int unsigned MR1_TDQS_BIT = 11; // 1: pin is termination strobe
  localparam int unsigned MR1_RTT2_BIT = 9; // nominal termination bits
  localparam int unsigned MR1_RTT1_BIT = 6;
  localparam int unsigned MR1_RTT0_BIT = 2;
  localparam int unsigned MR2_RTTWR_LSB = 9; // write termination field, 2 bits
  localparam int unsigned AP_BIT = 10; // auto-precharge / precharge-all
  localparam int unsigned BC_BIT = 12; // burst chop, low means chopped

  // burst beat counts
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;

  // decoded commands
  typedef enum logic [3:0] {
    CMD_DES = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_RD = 4'h3, CMD_WR = 4'h4,
    CMD_PRE = 4'h5, CMD_REF = 4'h6, CMD_MRS = 4'h7, CMD_ZQC = 4'h8
  } dci_cmd_type;

  // power states, one-hot
  typedef enum logic [3:0] {
    PS_ACTIVE = 4'b0001, PS_PD_PRE = 4'b0010, PS_PD_ACT = 4'b0100, PS_SELF_REF = 4'b1000
  } dci_ps_type;

  // command truth table on chip select, row strobe, column strobe and write enable
  function automatic dci_cmd_type dci_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    dci_cmd_type c;
    c = CMD_DES;
    if (!cs_n)
    begin
      case ({ras_n, cas_n, we_n})
        3'b011: c = CMD_ACT;
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b010: c = CMD_PRE;
        3'b001: c = CMD_REF;
        3'b000: c = CMD_MRS;
        3'b110: c = CMD_ZQC;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : dci_decode

  // true for an offset that holds a register
  function automatic logic dci_mapped(input logic [7:0] ofs);
    return (ofs == OFS_CTRL) || (ofs == OFS_STATUS) || (ofs == OFS_MR0) ||
           (ofs == OFS_MR1) || (ofs == OFS_MR2) || (ofs == OFS_MR3) || (ofs == OFS_CMDCNT);
  endfunction : dci_mapped

endpackage : dci_pkg

/* tb/dci_ctl_model.sv */
// behavioural memory controller driving the command, address and write data pins
`timescale 1ns/1ps
`default_nettype none
module dci_ctl_model
  import dci_pkg::*;
(
  input wire logic pclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic odt,
  output logic dqs,
  output logic [DQ_W-1:0] dq,
  output logic dm_tdqs
);
  // idle at time zero: deselected, clock enabled, no termination
  initial
  begin
    cke <= 1'b1;
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= 3'h7;
    ba <= '0;
    addr <= '0;
    odt <= 1'b0;
    dqs <= 1'b0;
    dq <= '0;
    dm_tdqs <= 1'b0;
  end

  // one command cycle, held across the sampling edge; afterwards the lines
  // are turned over so that a stale value can never pass for a live one
  task issue(input logic c, input logic [2:0] rcw, input logic [BA_W-1:0] b,
             input logic [ADDR_W-1:0] a, input logic e);
    @(posedge pclk);
    cke <= e;
    cs_n <= c;
    {ras_n, cas_n, we_n} <= rcw;
    ba <= b;
    addr <= a;
    @(posedge pclk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~rcw;
    ba <= ~b;
    addr <= ~a;
  endtask : issue

  // one write beat: the strobe turns over in either direction with data and mask
  task beat(input logic [DQ_W-1:0] d, input logic m);
    @(posedge pclk);
    dqs <= ~dqs;
    dq <= d;
    dm_tdqs <= m;
    @(posedge pclk);
    dq <= ~d;
    dm_tdqs <= ~m;
  endtask : beat

  // clock enable, changed only outside read and write accesses
  task set_cke(input logic v);
    @(posedge pclk);
    cke <= v;
  endtask : set_cke

  // termination request level
  task set_odt(input logic v);
    @(posedge pclk);
    odt <= v;
  endtask : set_odt
endmodule : dci_ctl_model
`default_nettype wire

/* tb/dci_ca_port_bench.sv */
// self-checking bench for the ddr3 command and address pin interface
`timescale 1ns/1ps
`default_nettype none
module dci_ca_port_bench
  import dci_pkg::*;
;
  localparam logic [2:0] RC_ACT = 3'b011; // row strobe, column strobe, write enable
  localparam logic [2:0] RC_RD = 3'b101;
  localparam logic [2:0] RC_WR = 3'b100;
  localparam logic [2:0] RC_PRE = 3'b010;
  localparam logic [2:0] RC_REF = 3'b001;
  localparam logic [2:0] RC_MRS = 3'b000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cke, cs_n, ras_n, cas_n, we_n, odt, dqs, dm_tdqs;
  logic [BA_W-1:0] ba, cmd_bank;
  logic [ADDR_W-1:0] addr, cmd_row;
  logic [DQ_W-1:0] dq, beat_data;
  logic [COL_W-1:0] cmd_col;
  dci_cmd_type cmd_code;
  logic cmd_valid, cmd_auto_pre, cmd_pre_all, cmd_chop, beat_valid, beat_keep;
  logic int_clk_en, out_drv_en, ca_buf_en, ck_buf_en, odt_buf_en;
  logic term_en, term_tdqs_n_en, mask_mode;
  int fail_count = 0; // mismatches
  int n_checks = 0; // comparisons
  logic [31:0] rd_q; // data of the last transfer
  logic rd_e; // error flag of the last transfer
  // mode register images; mr0 picks burst chop on the fly, mr1 turns termination on
  logic [14:0] mrv [4] = '{15'h0001, 15'h0004, 15'h0008, 15'h7a53};

  always #5 pclk = ~pclk; // 100 MHz

  dci_ca_port uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .odt(odt), .dqs(dqs), .dq(dq), .dm_tdqs(dm_tdqs),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
    .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre), .cmd_pre_all(cmd_pre_all),
    .cmd_chop(cmd_chop), .beat_valid(beat_valid), .beat_data(beat_data),
    .beat_keep(beat_keep), .int_clk_en(int_clk_en), .out_drv_en(out_drv_en),
    .ca_buf_en(ca_buf_en), .ck_buf_en(ck_buf_en), .odt_buf_en(odt_buf_en),
    .term_en(term_en), .term_tdqs_n_en(term_tdqs_n_en), .mask_mode(mask_mode));

  dci_ctl_model ctl (
    .pclk(pclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .odt(odt), .dqs(dqs), .dq(dq), .dm_tdqs(dm_tdqs));

  // verdict and end of run
  task end_of_test;
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // single comparison point; four-state so an unknown never matches a known value
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk

  // one apb transfer; the access phase lasts until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      fail_count++;
      end_of_test;
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // register read compared with its expected value
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd_q, x);
  endtask : rd

  // command through the controller model, then the decode pulse in the next cycle
  task cmd(input logic c, input logic [2:0] rcw, input logic [2:0] b, input logic [14:0] a,
           input logic e, input logic v);
    ctl.issue(c, rcw, b, a, e);
    @(negedge pclk);
    chk(cmd_valid, v);
  endtask : cmd

  // write beat and its masked result one cycle later
  task bt(input logic [7:0] d, input logic m, input logic v);
    ctl.beat(d, m);
    @(negedge pclk);
    chk({beat_valid, beat_data & {8{v}}, beat_keep & v}, {v, d & {8{v}}, ~m & v});
  endtask : bt

  // odt registered, then the termination outputs
  task term(input logic t, input logic tn, input logic mm);
    @(posedge pclk);
    @(negedge pclk);
    chk({term_en, term_tdqs_n_en, mask_mode}, {t, tn, mm});
  endtask : term

  // clock enable change, seen at the following edge
  task ck(input logic v);
    ctl.set_cke(v);
    @(posedge pclk);
    @(negedge pclk);
  endtask : ck

  // bounded wait for the return to the active state
  task wact;
    int n;
    n = 0;
    while (int_clk_en !== 1'b1 && n < 8)
    begin
      @(negedge pclk);
      n++;
    end
    chk({int_clk_en, ca_buf_en}, 2'b11);
    if (int_clk_en !== 1'b1)
      end_of_test;
  endtask : wact

  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({int_clk_en, out_drv_en, ca_buf_en, ck_buf_en, odt_buf_en, mask_mode, term_en},
        7'b1111110);
    rd(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, {28'h0, PS_ACTIVE});
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, {28'h0, PS_ACTIVE});
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd_e, 1'b1);
    chk(rd_q, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      cmd(1'b0, RC_MRS, 3'(i), mrv[i], 1'b1, 1'b1);
      rd(OFS_MR0 + 8'(4 * i), {17'h0, mrv[i]});
    end
    term(1'b0, 1'b0, 1'b1);
    ctl.set_odt(1'b1);
    term(1'b1, 1'b0, 1'b1);
    cmd(1'b0, RC_MRS, 3'h1, 15'h0804, 1'b1, 1'b1);
    term(1'b1, 1'b1, 1'b0);
    cmd(1'b0, RC_MRS, 3'h1, 15'h0000, 1'b1, 1'b1);
    term(1'b0, 1'b0, 1'b1);
    cmd(1'b0, RC_MRS, 3'h1, 15'h0004, 1'b1, 1'b1);
    cmd(1'b0, RC_ACT, 3'h3, 15'h5a5a, 1'b1, 1'b1);
    chk({cmd_code, cmd_bank, cmd_row}, {CMD_ACT, 3'h3, 15'h5a5a});
    rd(OFS_STATUS, {16'h0, 8'h08, 4'h0, PS_ACTIVE});
    cmd(1'b0, RC_WR, 3'h3, 15'h02a5, 1'b1, 1'b1);
    chk({cmd_code, cmd_col, cmd_chop, cmd_auto_pre}, {CMD_WR, 10'h2a5, 2'b10});
    for (int i = 0; i < 5; i++)
      bt(8'h31 + 8'(i), i[0], i < 4);
    cmd(1'b0, RC_RD, 3'h3, 15'h1455, 1'b1, 1'b1);
    chk({cmd_code, cmd_col, cmd_chop, cmd_auto_pre}, {CMD_RD, 10'h055, 2'b01});
    rd(OFS_STATUS, {28'h0, PS_ACTIVE});
    cmd(1'b1, RC_ACT, 3'h5, 15'h1234, 1'b1, 1'b0);
    cmd(1'b0, RC_ACT, 3'h1, 15'h7fff, 1'b1, 1'b1);
    chk(cmd_row, 15'h7fff);
    cmd(1'b0, RC_ACT, 3'h6, 15'h0000, 1'b1, 1'b1);
    rd(OFS_STATUS, {16'h0, 8'h42, 4'h0, PS_ACTIVE});
    cmd(1'b0, RC_PRE, 3'h1, 15'h0000, 1'b1, 1'b1);
    chk({cmd_code, cmd_bank, cmd_pre_all}, {CMD_PRE, 3'h1, 1'b0});
    rd(OFS_STATUS, {16'h0, 8'h40, 4'h0, PS_ACTIVE});
    cmd(1'b0, RC_REF, 3'h0, 15'h0000, 1'b1, 1'b1);
    chk(cmd_code, CMD_REF);
    cmd(1'b0, 3'b110, 3'h0, 15'h0000, 1'b1, 1'b1);
    chk(cmd_code, CMD_ZQC);
    cmd(1'b0, RC_MRS, 3'h0, 15'h0002, 1'b1, 1'b1);
    cmd(1'b0, RC_RD, 3'h6, 15'h1000, 1'b1, 1'b1);
    chk({cmd_chop, cmd_auto_pre}, 2'b10);
    cmd(1'b0, 3'b111, 3'h0, 15'h0000, 1'b1, 1'b0);
    ck(1'b0);
    rd(OFS_STATUS, {16'h0, 8'h40, 4'h0, PS_PD_ACT});
    chk({int_clk_en, out_drv_en, ca_buf_en, ck_buf_en, odt_buf_en}, 5'b00011);
    cmd(1'b0, RC_RD, 3'h6, 15'h0000, 1'b0, 1'b0);
    ck(1'b1);
    wact;
    cmd(1'b0, RC_PRE, 3'h0, 15'h0400, 1'b1, 1'b1);
    chk(cmd_pre_all, 1'b1);
    ck(1'b0);
    rd(OFS_STATUS, {28'h0, PS_PD_PRE});
    chk({ca_buf_en, ck_buf_en, odt_buf_en, term_en}, 4'b0111);
    ck(1'b1);
    wact;
    cmd(1'b0, RC_REF, 3'h0, 15'h0000, 1'b0, 1'b0);
    rd(OFS_STATUS, {28'h0, PS_SELF_REF});
    chk({ck_buf_en, odt_buf_en, term_en, int_clk_en}, 4'b0000);
    ck(1'b1);
    wact;
    apb(1'b1, OFS_CTRL, 32'h0);
    cmd(1'b0, RC_ACT, 3'h2, 15'h0000, 1'b1, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_CMDCNT, 32'h12);
    end_of_test;
  end
endmodule : dci_ca_port_bench
`default_nettype wire
